// ### bcoc_pkg.sv
/*
  bcoc_pkg: constants for the batch counter and output control block.
  Assumes a 125 MHz system clock; the batch spacing count derives from it.
*/
package bcoc_pkg;
  localparam int CLK_MHZ = 125;
  localparam int GAP_US = 1000;                    // least batch spacing
  localparam int GAP_CYC = GAP_US * CLK_MHZ;       // exact, no rounding
  localparam int GAP_W = 17;
  localparam int BPV_W = 14;
  localparam logic [13:0] BPV_MAX = 14'h270F;      // 9999
  localparam logic [13:0] BPV_RST = 14'h0000;
  localparam int CV_W = 24;
  localparam logic [23:0] CV_ZERO = 24'h000000;
  localparam logic [23:0] OVF_PATTERN = 24'hFFFFFF;
  localparam int DIP_W = 2;
  localparam int DIP_PM = 0;                       // +/- range variant
  localparam int DIP_TWO = 1;                      // two-stage model
  localparam int SYNC_W = DIP_W + 2;
  localparam logic [2:0] BOOT_LAST = 3'h4;         // filter settles first
endpackage

// ### bcoc_top.sv
/*
  bcoc_top: batch counter stage, control and batch output decisions,
  error freeze and power-up configuration sampling.
  Assumes the count core gives same-clock strobes and values; keys, reset
  input and dip switches are asynchronous pins. nrst marks power-up.
*/
`timescale 1ns/1ps
module bcoc_top #(
  parameter int GAP_CYC = bcoc_pkg::GAP_CYC
) (
  input wire logic clk_sys, // 125 MHz
  input wire logic nrst, // power-up reset, sync
  input wire logic [bcoc_pkg::DIP_W-1:0] dip_sw, // pin, async
  input wire logic reset_key, // pin, async
  input wire logic reset_in, // pin, async
  input wire logic nv_batch_on, // retained batch output state
  input wire logic counting, // core is counting
  input wire logic [bcoc_pkg::CV_W-1:0] cnt_pv, // present value
  input wire logic [bcoc_pkg::CV_W-1:0] cnt_sv, // edited set value
  input wire logic pv_below_min, // core underflow strobe
  input wire logic pv_above_max, // core overflow strobe
  input wire logic stage1_hit, // single set value reached
  input wire logic stage2_hit, // second_stage_setpoint reached
  input wire logic diag_err, // diagnostic error
  input wire logic cpu_fault, // processor fault
  input wire logic batch_rst, // batch count reset
  input wire logic [bcoc_pkg::BPV_W-1:0] batch_sv, // batch set value
  output logic ready_q, // configuration taken
  output logic cfg_pm_q, // +/- range variant
  output logic cfg_two_q, // two-stage model
  output logic ctrl_out_q, // control output
  output logic batch_out_q, // batch output, also to retain store
  output logic [bcoc_pkg::BPV_W-1:0] batch_pv_q, // batch present value
  output logic uflow_q, // underflow display
  output logic oflow_q, // overflow display
  output logic [bcoc_pkg::CV_W-1:0] err_disp_q, // all-F on overflow
  output logic pv_clear_q // clear present value in core
);
  import bcoc_pkg::*;

  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, pins;
  logic [2:0] boot_q;
  logic [GAP_W-1:0] gap_q;
  logic inhibit_q;
  logic rst_any, stage_hit, accept, hold, kill;

  // pins pass three flops; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= pins[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            filt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  assign pins = {dip_sw, reset_in, reset_key};
  assign rst_any = ready_q & (filt_q[0] | filt_q[1]);
  assign hold = uflow_q | oflow_q;
  assign kill = cpu_fault | diag_err | rst_any;
  assign stage_hit = cfg_two_q ? stage2_hit : stage1_hit;
  // a hit inside the guard window is dropped, not queued
  assign accept = ready_q & stage_hit & (gap_q == '0);

  // boot: let the filter settle, then take straps once
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      boot_q <= 3'h0;
      ready_q <= 1'b0;
      cfg_pm_q <= 1'b0;
      cfg_two_q <= 1'b0;
    end
    else if (!ready_q)
    begin
      boot_q <= boot_q + 3'h1;
      if (boot_q == BOOT_LAST)
      begin
        ready_q <= 1'b1;
        cfg_pm_q <= filt_q[DIP_PM+2];
        cfg_two_q <= filt_q[DIP_TWO+2];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      gap_q <= '0;
    else if (accept)
      gap_q <= GAP_W'(GAP_CYC - 1);
    else if (gap_q != '0)
      gap_q <= gap_q - GAP_W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      batch_pv_q <= BPV_RST;
    else if (batch_rst)
      batch_pv_q <= BPV_RST;
    else if (accept)
      batch_pv_q <= (batch_pv_q == BPV_MAX) ? BPV_RST :
                    batch_pv_q + 14'h0001;
  end

  // batch output ignores the reset key; only batch reset or fault drop it
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      batch_out_q <= 1'b0;
    else if (cpu_fault || (ready_q && batch_rst))
      batch_out_q <= 1'b0;
    else if (!ready_q)
    begin
      if (boot_q == BOOT_LAST)
        batch_out_q <= nv_batch_on;
    end
    else if (batch_sv != BPV_RST && batch_pv_q >= batch_sv)
      batch_out_q <= 1'b1;
  end

  // outside the +/- variant, a zero set at reset locks output until a nonzero set is entered
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      inhibit_q <= 1'b0;
    else if (rst_any)
      inhibit_q <= (cnt_sv == CV_ZERO) && !cfg_pm_q;
    else if (cnt_sv != CV_ZERO)
      inhibit_q <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      ctrl_out_q <= 1'b0;
    else if (kill)
      ctrl_out_q <= 1'b0;
    else if (hold || !ready_q)
      ctrl_out_q <= ctrl_out_q;
    else if (counting && !inhibit_q && cnt_pv == cnt_sv)
      ctrl_out_q <= 1'b1;
  end

  // error set wins over a reset seen in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      uflow_q <= 1'b0;
      oflow_q <= 1'b0;
      err_disp_q <= CV_ZERO;
    end
    else
    begin
      if (ready_q && cfg_pm_q && pv_below_min)
        uflow_q <= 1'b1;
      else if (rst_any)
        uflow_q <= 1'b0;
      if (ready_q && cfg_pm_q && pv_above_max)
      begin
        oflow_q <= 1'b1;
        err_disp_q <= OVF_PATTERN;
      end
      else if (rst_any)
      begin
        oflow_q <= 1'b0;
        err_disp_q <= CV_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      pv_clear_q <= 1'b0;
    else
      pv_clear_q <= rst_any | (ready_q & diag_err);
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_restore;
    !ready_q && !cpu_fault && boot_q == BOOT_LAST && nv_batch_on |=>
      batch_out_q;
  endproperty
  a_restore: assert property (p_restore)
    else $error("batch output not restored");

  property p_batch_reach;
    ready_q && !cpu_fault && !batch_rst && batch_sv != BPV_RST &&
      batch_pv_q >= batch_sv |=> batch_out_q;
  endproperty
  a_batch_reach: assert property (p_batch_reach)
    else $error("batch output missing at reach");

  property p_batch_keep;
    ready_q && batch_out_q && !cpu_fault && !batch_rst |=> batch_out_q;
  endproperty
  a_batch_keep: assert property (p_batch_keep)
    else $error("batch output dropped");

  property p_batch_zero;
    ready_q && batch_sv == BPV_RST && !batch_out_q |=> !batch_out_q;
  endproperty
  a_batch_zero: assert property (p_batch_zero)
    else $error("batch output with zero set");

  property p_wrap;
    accept && !batch_rst && batch_pv_q == BPV_MAX |=> batch_pv_q == BPV_RST;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("batch present did not wrap");

  property p_brst;
    batch_rst |=> batch_pv_q == BPV_RST;
  endproperty
  a_brst: assert property (p_brst)
    else $error("batch present not held at zero");

  property p_gap;
    accept |=> (!accept && gap_q != '0) [*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("batch count-ups too close");

  property p_fault;
    cpu_fault |=> !ctrl_out_q && !batch_out_q;
  endproperty
  a_fault: assert property (p_fault)
    else $error("outputs on after fault");

  property p_freeze;
    ready_q && hold && !kill |=> $stable(ctrl_out_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("output moved during error");

  sequence s_rst_zero;
    rst_any && cnt_sv == CV_ZERO && !cfg_pm_q ##1 !rst_any;
  endsequence
  property p_zero_reset;
    s_rst_zero ##0 (cnt_sv == CV_ZERO && !hold) |=> !ctrl_out_q;
  endproperty
  a_zero_reset: assert property (p_zero_reset)
    else $error("output after zero-set reset");

  property p_match;
    ready_q && counting && !kill && !hold && !inhibit_q &&
      cnt_pv == cnt_sv |=> ctrl_out_q;
  endproperty
  a_match: assert property (p_match)
    else $error("control output missing on match");

  property p_straps;
    ready_q |=> $stable(cfg_pm_q) && $stable(cfg_two_q);
  endproperty
  a_straps: assert property (p_straps)
    else $error("straps changed while powered");
endmodule

// ### bcoc_stage_model.sv
/*
  bcoc_stage_model: count stage strobes seen from the batch block.
  Assumes fire is a one-cycle request raised just after a clk_sys edge.
*/
`timescale 1ns/1ps
module bcoc_stage_model (
  input wire logic clk_sys, // system clock
  input wire logic fire, // stage reached request
  input wire logic two, // two-stage model
  output logic stage1_hit, // single set reached
  output logic stage2_hit // second_stage_setpoint reached
);
  // one strobe per request, registered like the real core
  always_ff @(posedge clk_sys)
  begin
    stage1_hit <= fire && !two;
    stage2_hit <= fire && two;
  end
endmodule

// ### batch_counter_output_control_bench.sv
/*
  bench for bcoc_top with a short batch spacing.
  Assumes bcoc_pkg and bcoc_stage_model are compiled first.
*/
`timescale 1ns/1ps
module batch_counter_output_control_bench;
  import bcoc_pkg::*;
  localparam int GAP = 16;
  logic clk_sys = 1'b0;
  logic nrst, reset_key, reset_in, nv_batch_on, counting, fire, two;
  logic pv_below_min, pv_above_max, diag_err, cpu_fault, batch_rst;
  logic stage1_hit, stage2_hit, ready_q, cfg_pm_q, cfg_two_q, ctrl_out_q;
  logic batch_out_q, uflow_q, oflow_q, pv_clear_q;
  logic [1:0] dip_sw;
  logic [23:0] cnt_pv, cnt_sv, err_disp_q;
  logic [13:0] batch_sv, batch_pv_q, exp_pv;
  logic [31:0] seed = 32'h3B4B64A6;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  bcoc_top #(.GAP_CYC(GAP)) u_bcoc_top (.clk_sys, .nrst, .dip_sw,
    .reset_key, .reset_in, .nv_batch_on, .counting, .cnt_pv, .cnt_sv,
    .pv_below_min, .pv_above_max, .stage1_hit, .stage2_hit, .diag_err,
    .cpu_fault, .batch_rst, .batch_sv, .ready_q, .cfg_pm_q, .cfg_two_q,
    .ctrl_out_q, .batch_out_q, .batch_pv_q, .uflow_q, .oflow_q,
    .err_disp_q, .pv_clear_q);
  bcoc_stage_model u_bcoc_stage_model (.clk_sys, .fire, .two,
    .stage1_hit, .stage2_hit);

  always #4 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // batch present value after one accepted count-up
  function automatic logic [13:0] nxt(input logic [13:0] v);
    return (v == BPV_MAX) ? BPV_RST : v + 14'h0001;
  endfunction

  task automatic chkv(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chkv({23'h0, got}, {23'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // outputs are read at the falling edge, well settled
  task automatic look(input int n);
    cyc(n);
    @(negedge clk_sys);
  endtask

  task automatic hit(input int gap);
    cyc(1);
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    look(gap);
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // run needs well under 1000 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      end_sim();
    end
  end

  initial
  begin
    {nrst, reset_key, reset_in, counting, fire, two} = '0;
    {pv_below_min, pv_above_max, diag_err, cpu_fault, batch_rst} = '0;
    {cnt_pv, cnt_sv, batch_sv, exp_pv} = '0;
    {dip_sw, nv_batch_on} = 3'h5;
    cyc(5);
    nrst <= 1'b1;
    two <= 1'b1;
    look(5);
    chkb(ready_q, 1'b1);
    chkb(cfg_two_q, 1'b1);
    chkb(batch_out_q, 1'b1);
    cyc(1);
    dip_sw <= 2'h1;
    look(8);
    chkb(cfg_pm_q, 1'b0);
    $display("power-up test done");
    cyc(1);
    batch_rst <= 1'b1;
    hit(GAP);
    chkv(24'(batch_pv_q), 24'h0);
    cyc(1);
    batch_rst <= 1'b0;
    two <= 1'b0;
    hit(GAP);
    chkv(24'(batch_pv_q), 24'h0);
    cyc(1);
    two <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      hit(GAP + int'(seed[1:0]));
      exp_pv = nxt(exp_pv);
    end
    chkv(24'(batch_pv_q), 24'(exp_pv));
    chkb(batch_out_q, 1'b0);
    hit(2);
    hit(GAP);
    exp_pv = nxt(exp_pv);
    chkv(24'(batch_pv_q), 24'(exp_pv));
    cyc(1);
    batch_sv <= exp_pv + 14'h0006;
    look(3);
    chkb(batch_out_q, 1'b0);
    cyc(1);
    batch_sv <= exp_pv - 14'h0002;
    look(3);
    chkb(batch_out_q, 1'b1);
    cyc(1);
    seed = xs(seed);
    batch_sv <= {6'h01, seed[7:0]};
    look(3);
    chkb(batch_out_q, 1'b1);
    $display("batch test done");
    cyc(1);
    reset_key <= 1'b1;
    look(8);
    chkb(pv_clear_q, 1'b1);
    cyc(1);
    seed = xs(seed);
    reset_key <= 1'b0;
    counting <= 1'b1;
    cnt_sv <= {8'h00, seed[15:1], 1'b1};
    cnt_pv <= {8'h00, seed[15:1], 1'b1};
    look(8);
    chkb(ctrl_out_q, 1'b1);
    cyc(1);
    diag_err <= 1'b1;
    look(3);
    chkb(ctrl_out_q, 1'b0);
    cyc(1);
    diag_err <= 1'b0;
    cpu_fault <= 1'b1;
    look(3);
    chkb(batch_out_q, 1'b0);
    cyc(1);
    {cpu_fault, counting, reset_in} <= 3'h1;
    {cnt_sv, cnt_pv} <= {24'h0, 24'h5};
    look(8);
    cyc(1);
    reset_in <= 1'b0;
    counting <= 1'b1;
    cnt_pv <= CV_ZERO;
    look(8);
    chkb(ctrl_out_q, 1'b0);
    $display("control test done");
    cyc(1);
    nrst <= 1'b0;
    counting <= 1'b0;
    {dip_sw, nv_batch_on} <= 3'h2;
    cyc(5);
    nrst <= 1'b1;
    look(5);
    chkb(cfg_pm_q, 1'b1);
    chkb(batch_out_q, 1'b0);
    cyc(1);
    pv_above_max <= 1'b1;
    cyc(1);
    pv_above_max <= 1'b0;
    pv_below_min <= 1'b1;
    cyc(1);
    pv_below_min <= 1'b0;
    look(2);
    chkv(err_disp_q, OVF_PATTERN);
    chkb(oflow_q, 1'b1);
    chkb(uflow_q, 1'b1);
    cyc(1);
    reset_in <= 1'b1;
    look(8);
    chkb(oflow_q, 1'b0);
    chkb(uflow_q, 1'b0);
    $display("range error test done");
    cyc(1);
    {reset_in, two} <= 2'h0;
    batch_sv <= 14'h0002;
    exp_pv = BPV_RST;
    for (int i = 0; i < 2; i++)
    begin
      hit(GAP);
      exp_pv = nxt(exp_pv);
      chkb(batch_out_q, exp_pv >= 14'h0002);
    end
    chkv(24'(batch_pv_q), 24'(exp_pv));
    $display("one-stage batch test done");
    end_sim();
  end
endmodule
